// ==== logic/sfs_regs.sv ====
// Frame statistics and configuration register bank of the navigation sensor
// What this block does
// - Sums all 900 pixels of each frame in 16 bits and shows the upper byte.
// - The brightness sum register always reads between 0 and 221.
// - The brightness sum is refreshed at the end of every frame.
// - The peak pixel register holds the largest 6-bit pixel, upper bits zero.
// - Laser gating 0 keeps the laser on, 1 lights it only when illumination is needed.
// - Writing the self-test bit runs the tests and leaves a 16-bit result word.
// - A laser fault during the self test makes the result a failure.
// - Test end restores defaults; the host configures only after the test.
// - The self test lasts 200 ms.
// - The resolution bit selects about 400 cpi at 0 and 800 cpi at 1.
// - Busy reads 1 until two frames after a write to the frame-period ceiling.
// - The pull-up disable bit turns off the port pull-up sources.
// - The auto-gain disable bit holds the shutter at its programmed maximum.
// - The constant frame rate bit fixes the frame period at its maximum bound.
`timescale 1ns/1ns
module sfs_regs #(
    parameter int PIXEL_COUNT = sfs_pkg::PIXELS_PER_FRAME,
    parameter int TEST_CYCLES = sfs_pkg::SELF_TEST_CYCLES,
    parameter logic [15:0] PASS_SIGNATURE = 16'hA5C3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic pixel_valid,
    input wire logic [5:0] pixel_value,
    input wire logic frame_end,
    input wire logic ceiling_write,
    input wire logic illum_needed,
    input wire logic laser_fault,
    output logic laser_on,
    output logic cpi_select,
    output logic port_pullup_disable,
    output logic auto_gain_disable,
    output logic constant_frame_rate,
    output logic test_running,
    output logic test_done
);
    // Sum must fit 16 bits and the test needs a start and an end cycle
    if (PIXEL_COUNT < 1 || PIXEL_COUNT * 63 > 65535 || TEST_CYCLES < 2) begin : g_bad_params
        $error("sfs_regs: unsupported parameter values");
    end

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_FAIL} sfs_test_e;

    logic [15:0] acc_q, acc_d;
    logic [7:0] sum_q, sum_d;
    logic [5:0] peak_run_q, peak_run_d, peak_q, peak_d;
    logic [7:0] main_q, main_d, ext_q, ext_d;
    logic [1:0] busy_cnt_q, busy_cnt_d;
    logic [15:0] result_q, result_d;
    logic [31:0] tcnt_q, tcnt_d;
    sfs_test_e st_q, st_d;
    logic [7:0] rdata_q, rdata_d;
    logic laser_q, laser_d, done_q, done_d;
    logic running_q, running_d;
    // Fault is a pin level from the laser driver, so it is synchronised first
    logic fault_meta_q, fault_sync_q;
    logic [5:0] peak_in;
    logic [15:0] acc_in;

    // Only the masked bits take the written value
    function automatic logic [7:0] merge_bits(input logic [7:0] old_bits,
                                              input logic [7:0] new_bits,
                                              input logic [7:0] mask);
        return (old_bits & ~mask) | (new_bits & mask);
    endfunction

    always_comb begin
        acc_in = acc_q + {10'h000, pixel_value};
        peak_in = (pixel_value > peak_run_q) ? pixel_value : peak_run_q;
        acc_d = acc_q;
        peak_run_d = peak_run_q;
        sum_d = sum_q;
        peak_d = peak_q;
        if (pixel_valid) begin
            acc_d = acc_in;
            peak_run_d = peak_in;
        end
        if (frame_end) begin
            sum_d = pixel_valid ? acc_in[15:8] : acc_q[15:8];
            if (sum_d > sfs_pkg::BRIGHT_SUM_MAX) begin
                sum_d = sfs_pkg::BRIGHT_SUM_MAX;
            end
            peak_d = pixel_valid ? peak_in : peak_run_q;
            acc_d = 16'h0000;
            peak_run_d = 6'h00;
        end
    end

    always_comb begin
        main_d = main_q;
        ext_d = ext_q;
        busy_cnt_d = busy_cnt_q;
        st_d = st_q;
        tcnt_d = tcnt_q;
        result_d = result_q;
        done_d = 1'b0;
        if (ceiling_write) begin
            busy_cnt_d = 2'(sfs_pkg::BUSY_FRAMES);
        end else if (frame_end && busy_cnt_q != 2'h0) begin
            busy_cnt_d = busy_cnt_q - 2'h1;
        end
        ext_d[sfs_pkg::EXT_BUSY_BIT] = (busy_cnt_d != 2'h0);
        // Writes ignored during the test; the host must stay off the port anyway
        if (reg_wr && st_q == ST_IDLE) begin
            if (reg_addr == sfs_pkg::ADDR_MAIN_CFG) begin
                // cpi select, self-test and laser gating stored
                main_d = merge_bits(sfs_pkg::MAIN_CFG_RESET, reg_wdata, sfs_pkg::MAIN_WRITE_MASK);
            end
            if (reg_addr == sfs_pkg::ADDR_EXT_CFG) begin
                ext_d = merge_bits(ext_d, reg_wdata, sfs_pkg::EXT_WRITE_MASK)
                      | (8'h01 << sfs_pkg::EXT_FIXED_ONE_BIT);
            end
        end
        case (st_q)
            ST_IDLE: begin
                if (main_d[sfs_pkg::MAIN_SELF_TEST_BIT]) begin
                    st_d = ST_RUN;
                    tcnt_d = 32'h0000_0000;
                end
            end
            ST_RUN, ST_FAIL: begin
                tcnt_d = tcnt_q + 32'h0000_0001;
                if (fault_sync_q) begin
                    st_d = ST_FAIL;
                end
                // fixed test length
                // 32-bit count covers the full length at the nominal clock
                if (tcnt_q == 32'(TEST_CYCLES - 1)) begin
                    result_d = (st_q == ST_FAIL || fault_sync_q) ? ~PASS_SIGNATURE
                                                                 : PASS_SIGNATURE;
                    main_d = sfs_pkg::MAIN_CFG_RESET;
                    ext_d = sfs_pkg::EXT_CFG_RESET;
                    busy_cnt_d = 2'h0;
                    st_d = ST_IDLE;
                    done_d = 1'b1;
                end
            end
            default: st_d = ST_IDLE;
        endcase
        running_d = (st_d != ST_IDLE);
    end

    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            case (reg_addr)
                sfs_pkg::ADDR_BRIGHT_SUM: rdata_d = sum_q;
                sfs_pkg::ADDR_PEAK_PIXEL: rdata_d = {2'b00, peak_q};
                sfs_pkg::ADDR_MAIN_CFG: rdata_d = main_q;
                sfs_pkg::ADDR_EXT_CFG: rdata_d = ext_q;
                sfs_pkg::ADDR_RESULT_LO: rdata_d = result_q[7:0];
                sfs_pkg::ADDR_RESULT_HI: rdata_d = result_q[15:8];
                default: rdata_d = 8'h00;
            endcase
        end
        laser_d = main_q[sfs_pkg::MAIN_LASER_GATE_BIT] ? illum_needed : 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= 16'h0000;
            peak_run_q <= 6'h00;
            sum_q <= sfs_pkg::STAT_RESET;
            peak_q <= 6'h00;
            main_q <= sfs_pkg::MAIN_CFG_RESET;
            ext_q <= sfs_pkg::EXT_CFG_RESET;
            busy_cnt_q <= 2'h0;
            st_q <= ST_IDLE;
            tcnt_q <= 32'h0000_0000;
            result_q <= 16'h0000;
            rdata_q <= 8'h00;
            laser_q <= 1'b1;
            done_q <= 1'b0;
            running_q <= 1'b0;
            fault_meta_q <= 1'b0;
            fault_sync_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            peak_run_q <= peak_run_d;
            sum_q <= sum_d;
            peak_q <= peak_d;
            main_q <= main_d;
            ext_q <= ext_d;
            busy_cnt_q <= busy_cnt_d;
            st_q <= st_d;
            tcnt_q <= tcnt_d;
            result_q <= result_d;
            rdata_q <= rdata_d;
            laser_q <= laser_d;
            done_q <= done_d;
            running_q <= running_d;
            fault_meta_q <= laser_fault;
            fault_sync_q <= fault_meta_q;
        end
    end

    assign reg_rdata = rdata_q;
    assign laser_on = laser_q;
    assign cpi_select = main_q[sfs_pkg::MAIN_CPI_BIT];
    // pull-up disable, gain and rate holds driven out
    assign port_pullup_disable = ext_q[sfs_pkg::EXT_PULLUP_DIS_BIT];
    assign auto_gain_disable = ext_q[sfs_pkg::EXT_AUTO_GAIN_DIS_BIT];
    assign constant_frame_rate = ext_q[sfs_pkg::EXT_CONST_RATE_BIT];
    assign test_running = running_q;
    assign test_done = done_q;
endmodule

// ==== logic/sfs_pkg.sv ====
// Constants shared by the frame statistics and configuration register bank
package sfs_pkg;
    localparam logic [6:0] ADDR_BRIGHT_SUM = 7'h06;
    localparam logic [6:0] ADDR_PEAK_PIXEL = 7'h07;
    localparam logic [6:0] ADDR_RSVD_A = 7'h08;
    localparam logic [6:0] ADDR_RSVD_B = 7'h09;
    localparam logic [6:0] ADDR_MAIN_CFG = 7'h0A;
    localparam logic [6:0] ADDR_EXT_CFG = 7'h0B;
    localparam logic [6:0] ADDR_RESULT_LO = 7'h0C;
    localparam logic [6:0] ADDR_RESULT_HI = 7'h0D;
    localparam logic [7:0] MAIN_CFG_RESET = 8'h49;
    localparam logic [7:0] EXT_CFG_RESET = 8'h08;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam int MAIN_LASER_GATE_BIT = 6;
    localparam int MAIN_SELF_TEST_BIT = 5;
    localparam int MAIN_CPI_BIT = 4;
    localparam int MAIN_FIXED_ONE_BIT = 3;
    localparam int EXT_BUSY_BIT = 7;
    localparam int EXT_FIXED_ONE_BIT = 3;
    localparam int EXT_PULLUP_DIS_BIT = 2;
    localparam int EXT_AUTO_GAIN_DIS_BIT = 1;
    localparam int EXT_CONST_RATE_BIT = 0;
    localparam logic [7:0] MAIN_WRITE_MASK = 8'h70;
    localparam logic [7:0] EXT_WRITE_MASK = 8'h07;
    localparam int PIXELS_PER_FRAME = 900;
    localparam logic [7:0] BRIGHT_SUM_MAX = 8'hDD;
    localparam logic [5:0] PEAK_MAX = 6'h3F;
    localparam int BUSY_FRAMES = 2;
    localparam int SELF_TEST_MS = 200;
    localparam int CLK_KHZ = 250000;
    localparam int SELF_TEST_CYCLES = SELF_TEST_MS * CLK_KHZ;
endpackage

// ==== verif/sfs_regs_asserts.sv ====
// Port-level checker for the register bank
`timescale 1ns/1ns
module sfs_regs_asserts #(
    parameter int TEST_CYCLES = 100
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic illum_needed,
    input wire logic laser_on,
    input wire logic cpi_select,
    input wire logic port_pullup_disable,
    input wire logic auto_gain_disable,
    input wire logic constant_frame_rate,
    input wire logic test_running,
    input wire logic test_done
);
    int run_q;
    int run_d;
    logic cfg_wr;
    assign cfg_wr = reg_wr && !test_running;
    always_comb run_d = test_running ? run_q + 1 : 0;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) run_q <= 0;
        else run_q <= run_d;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_peak_top_zero: assert property (reg_rd && reg_addr == 7'h07 |=> reg_rdata[7:6] == 2'b00)
        else $error("peak upper bits set");
    a_sum_ceiling: assert property (reg_rd && reg_addr == 7'h06 |=> reg_rdata <= 8'hDD)
        else $error("brightness sum above ceiling");
    a_laser_gate: assert property (!laser_on |-> !$past(illum_needed))
        else $error("laser off without gating");
    a_cpi_write: assert property (cfg_wr && reg_addr == 7'h0A |=> cpi_select == $past(reg_wdata[4]))
        else $error("resolution bit not taken");
    a_ext_write: assert property (cfg_wr && reg_addr == 7'h0B |=>
        {port_pullup_disable, auto_gain_disable, constant_frame_rate} == $past(reg_wdata[2:0]))
        else $error("extended bits not taken");
    a_test_start: assert property (cfg_wr && reg_addr == 7'h0A && reg_wdata[5] |=> test_running)
        else $error("self test did not start");
    a_test_restore: assert property (test_done |-> ##[0:1] (!cpi_select && !constant_frame_rate))
        else $error("defaults not restored");
    a_test_length: assert property (test_done |-> run_q >= TEST_CYCLES - 1 && run_q <= TEST_CYCLES + 1)
        else $error("self test length wrong");
    c_done: cover property (test_done);
    c_dark: cover property (!laser_on);
    c_ext: cover property (reg_wr && reg_addr == 7'h0B);
endmodule
bind sfs_regs sfs_regs_asserts #(.TEST_CYCLES(TEST_CYCLES)) i_asserts (.clk(clk), .rst_n(rst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .illum_needed(illum_needed), .laser_on(laser_on),
    .cpi_select(cpi_select), .port_pullup_disable(port_pullup_disable),
    .auto_gain_disable(auto_gain_disable), .constant_frame_rate(constant_frame_rate),
    .test_running(test_running), .test_done(test_done));

// ==== verif/sfs_host.sv ====
// Host controller model on the register port
`timescale 1ns/1ns
module sfs_host (
    input wire logic clk,
    input wire logic test_running,
    input wire logic [7:0] reg_rdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic [6:0] reg_addr,
    output logic [7:0] reg_wdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        while (test_running === 1'b1) @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= (a == 7'h0A) ? ((d & 8'h7F) | 8'h08) : d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge clk);
        d = reg_rdata;
    endtask
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for the register bank
`timescale 1ns/1ns
module tb_top;
    // Arbitrary pass word
    localparam logic [15:0] SIG = 16'h5A3C;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic pixel_valid = 1'b0;
    logic frame_end = 1'b0;
    logic ceiling_write = 1'b0;
    logic illum_needed = 1'b1;
    logic laser_fault = 1'b0;
    logic [5:0] pixel_value = 6'h00;
    logic reg_wr, reg_rd, laser_on, cpi, pud, agd, cfr, running, done;
    logic [6:0] addr;
    logic [7:0] wdata, rdata, rv;
    logic [15:0] res;
    logic [7:0] rst_exp [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h49, 8'h08};
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int sum, peak, v;
    always #2 clk = ~clk;
    sfs_regs #(.TEST_CYCLES(100), .PASS_SIGNATURE(SIG)) i_dut (.clk(clk), .rst_n(rst_n),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
        .pixel_valid(pixel_valid), .pixel_value(pixel_value), .frame_end(frame_end),
        .ceiling_write(ceiling_write), .illum_needed(illum_needed), .laser_fault(laser_fault),
        .laser_on(laser_on), .cpi_select(cpi), .port_pullup_disable(pud),
        .auto_gain_disable(agd), .constant_frame_rate(cfr), .test_running(running),
        .test_done(done));
    sfs_host i_host (.clk(clk), .test_running(running), .reg_rdata(rdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(addr), .reg_wdata(wdata));
    task automatic give_verdict();
        $display("Checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
        i_host.rd(a, rv);
        chk(rv, exp);
    endtask
    // Mode 0 dark, 1 random, 2 saturated
    task automatic frame(input int mode);
        sum = 0;
        peak = 0;
        for (int i = 0; i < 900; i++) begin
            v = (mode == 2) ? 63 : (mode == 1) ? $urandom_range(63) : 0;
            sum += v;
            if (v > peak) peak = v;
            @(posedge clk);
            pixel_valid <= 1'b1;
            pixel_value <= 6'(v);
            frame_end <= (i == 899);
        end
        @(posedge clk);
        pixel_valid <= 1'b0;
        frame_end <= 1'b0;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            give_verdict();
        end
    end
    initial begin
        void'($urandom(68140));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rst_exp[i]) rchk(7'h06 + 7'(i), rst_exp[i]);
        rchk(7'h30, 8'h00);
        for (int m = 1; m < 3; m++) begin
            frame(m);
            rchk(7'h06, 8'(sum >> 8));
            rchk(7'h07, 8'(peak));
        end
        i_host.wr(7'h06, 8'h00);
        rchk(7'h06, 8'hDD);
        illum_needed <= 1'b0;
        repeat (3) @(posedge clk);
        chk(laser_on, 1'b0);
        i_host.wr(7'h0A, 8'h19);
        repeat (2) @(posedge clk);
        chk({laser_on, cpi}, 2'h3);
        rchk(7'h0A, 8'h19);
        i_host.wr(7'h0B, 8'hF7);
        rchk(7'h0B, 8'h0F);
        chk({pud, agd, cfr}, 3'h7);
        ceiling_write <= 1'b1;
        @(posedge clk);
        ceiling_write <= 1'b0;
        rchk(7'h0B, 8'h8F);
        frame(0);
        rchk(7'h0B, 8'h8F);
        frame(0);
        rchk(7'h0B, 8'h0F);
        for (int f = 0; f < 2; f++) begin
            rst_n <= 1'b0;
            repeat (2) @(posedge clk);
            rst_n <= 1'b1;
            laser_fault <= f[0];
            res = f ? ~SIG : SIG;
            i_host.wr(7'h0B, 8'h07);
            i_host.wr(7'h0A, 8'h39);
            for (int w = 0; w < 300 && done !== 1'b1; w++) @(posedge clk);
            chk(done, 1'b1);
            rchk(7'h0D, res[15:8]);
            rchk(7'h0C, res[7:0]);
            rchk(7'h0A, 8'h49);
            rchk(7'h0B, 8'h08);
        end
        give_verdict();
    end
endmodule
